// [vbc_control_port.sv]
`timescale 1ns/1ps
`default_nettype none

module vbc_control_port (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        address_strap_bit1_i,
	input  wire logic        address_strap_bit0_i,
	input  wire logic        power_up_state_strap_i,
	input  wire logic        input_select_source_strap_i,
	input  wire logic        input_select_pin_i,
	output logic [23:0]      ch_cfg_o,
	output logic [7:0]       sync_cfg_o,
	output logic [2:0]       mux_sel_b_o
);

	// ==========================================================
	// link domain: capture each bit on the rising bus clock
	logic bit_ff;
	logic bit_tog_ff;

	always_ff @(posedge scl_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_ff     <= 1'b0;
			bit_tog_ff <= 1'b0;
		end else begin
			bit_ff     <= sda_i;
			bit_tog_ff <= ~bit_tog_ff;
		end
	end

	// ==========================================================
	// synchronisers; first stage feeds only the second
	logic [1:0] scl_sync_ff, sda_sync_ff, tog_sync_ff;
	logic [1:0] ad1_sync_ff, ad0_sync_ff, pwr_sync_ff, src_sync_ff, pin_sync_ff;
	logic       scl_d_ff, sda_d_ff, tog_d_ff;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			tog_sync_ff <= 2'h0;
			ad1_sync_ff <= 2'h0;
			ad0_sync_ff <= 2'h0;
			pwr_sync_ff <= 2'h0;
			src_sync_ff <= 2'h0;
			pin_sync_ff <= 2'h0;
			scl_d_ff    <= 1'b1;
			sda_d_ff    <= 1'b1;
			tog_d_ff    <= 1'b0;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
			tog_sync_ff <= {tog_sync_ff[0], bit_tog_ff};
			ad1_sync_ff <= {ad1_sync_ff[0], address_strap_bit1_i};
			ad0_sync_ff <= {ad0_sync_ff[0], address_strap_bit0_i};
			pwr_sync_ff <= {pwr_sync_ff[0], power_up_state_strap_i};
			src_sync_ff <= {src_sync_ff[0], input_select_source_strap_i};
			pin_sync_ff <= {pin_sync_ff[0], input_select_pin_i};
			scl_d_ff    <= scl_sync_ff[1];
			sda_d_ff    <= sda_sync_ff[1];
			tog_d_ff    <= tog_sync_ff[1];
		end
	end

	wire start_w = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
	wire stop_w  = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];
	// oversampled bus clock
	// fast mode low phase is long enough for the few cycles of synchroniser delay
	wire fall_w  = scl_d_ff & ~scl_sync_ff[1];
	// bit_ff is stable for a whole bus clock once the toggle shows up here
	wire bit_ev_w = tog_sync_ff[1] ^ tog_d_ff;

	// ==========================================================
	// strap capture, once after reset
	logic [1:0] strap_cnt_ff;
	logic       strap_done_ff;
	logic [1:0] addr_low_ff;

	wire strap_take_w = ~strap_done_ff & (strap_cnt_ff == vbc_pkg::STRAP_WAIT);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_cnt_ff  <= 2'h0;
			strap_done_ff <= 1'b0;
			addr_low_ff   <= 2'h0;
		end else begin
			if (!strap_done_ff)
				strap_cnt_ff <= strap_cnt_ff + 2'h1;
			if (strap_take_w) begin
				strap_done_ff <= 1'b1;
				// strap level is the address bit
				addr_low_ff   <= {ad1_sync_ff[1], ad0_sync_ff[1]};
			end
		end
	end

	// ==========================================================
	// protocol engine
	vbc_pkg::vbc_state_type state_ff;
	logic [7:0] shift_ff;
	logic [3:0] cnt_ff;
	logic       rw_ff;
	logic       first_ff;
	logic [1:0] ptr_ff;
	logic       sda_oe_ff;
	logic [7:0] cfg_ff [0:3];

	wire addr_hit_w = (shift_ff[7:1] == {vbc_pkg::ADDR_FIXED, addr_low_ff});
	wire [7:0] tx_byte_w = cfg_ff[ptr_ff];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff  <= vbc_pkg::ST_IDLE;
			shift_ff  <= 8'h00;
			cnt_ff    <= 4'h0;
			rw_ff     <= 1'b0;
			first_ff  <= 1'b0;
			ptr_ff    <= 2'h0;
			sda_oe_ff <= 1'b0;
			// all channels off until the strap is seen
			for (int i = 0; i < 4; i++)
				cfg_ff[i] <= vbc_pkg::CH_RST_OFF;
		end else if (strap_take_w) begin
			for (int i = 0; i < vbc_pkg::NUM_CH; i++)
				cfg_ff[i] <= pwr_sync_ff[1] ? vbc_pkg::CH_RST_MON : vbc_pkg::CH_RST_OFF;
			cfg_ff[vbc_pkg::PTR_SYNC] <= pwr_sync_ff[1] ? vbc_pkg::SYNC_RST_ON : vbc_pkg::SYNC_RST_OFF;
		end else if (stop_w) begin
			state_ff  <= vbc_pkg::ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else if (start_w) begin
			// accepted whatever the channel settings are
			state_ff  <= vbc_pkg::ST_ADDR;
			cnt_ff    <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
				vbc_pkg::ST_ADDR, vbc_pkg::ST_RX: begin
					if (bit_ev_w) begin
						shift_ff <= {shift_ff[6:0], bit_ff};
						cnt_ff   <= cnt_ff + 4'h1;
					end else if (fall_w && cnt_ff == 4'h8) begin
						if (state_ff == vbc_pkg::ST_ADDR) begin
							if (addr_hit_w) begin
								// hold data low through the ninth clock
								sda_oe_ff <= 1'b1;
								rw_ff     <= shift_ff[0];
								first_ff  <= 1'b1;
								state_ff  <= vbc_pkg::ST_ACK;
							end else begin
								state_ff <= vbc_pkg::ST_IDLE;
							end
						end else begin
							sda_oe_ff <= 1'b1;
							first_ff  <= 1'b0;
							state_ff  <= vbc_pkg::ST_ACK;
							if (first_ff) begin
								ptr_ff <= shift_ff[1:0];
							end else begin
								cfg_ff[ptr_ff] <= shift_ff;
								ptr_ff         <= ptr_ff + 2'h1;
							end
						end
					end
				end
				vbc_pkg::ST_ACK: begin
					if (fall_w) begin
						cnt_ff <= 4'h0;
						if (rw_ff) begin
							sda_oe_ff <= ~tx_byte_w[7];
							shift_ff  <= {tx_byte_w[6:0], 1'b1};
							state_ff  <= vbc_pkg::ST_TX;
						end else begin
							sda_oe_ff <= 1'b0;
							state_ff  <= vbc_pkg::ST_RX;
						end
					end
				end
				vbc_pkg::ST_TX: begin
					if (bit_ev_w) begin
						cnt_ff <= cnt_ff + 4'h1;
					end else if (fall_w) begin
						if (cnt_ff == 4'h8) begin
							sda_oe_ff <= 1'b0;
							ptr_ff    <= ptr_ff + 2'h1;
							state_ff  <= vbc_pkg::ST_TXACK;
						end else begin
							sda_oe_ff <= ~shift_ff[7];
							shift_ff  <= {shift_ff[6:0], 1'b1};
						end
					end
				end
				vbc_pkg::ST_TXACK: begin
					// a master nack ends the read
					if (bit_ev_w && bit_ff) begin
						state_ff <= vbc_pkg::ST_IDLE;
					end else if (fall_w) begin
						cnt_ff    <= 4'h0;
						sda_oe_ff <= ~tx_byte_w[7];
						shift_ff  <= {tx_byte_w[6:0], 1'b1};
						state_ff  <= vbc_pkg::ST_TX;
					end
				end
				default: begin
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// outputs
	logic [23:0] ch_cfg_ff;
	logic [7:0]  sync_cfg_ff;
	logic [2:0]  mux_ff;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ch_cfg_ff   <= 24'h000000;
			sync_cfg_ff <= 8'h00;
			mux_ff      <= 3'h0;
		end else begin
			ch_cfg_ff   <= {cfg_ff[2], cfg_ff[1], cfg_ff[0]};
			sync_cfg_ff <= cfg_ff[vbc_pkg::PTR_SYNC];
			// source strap low: pin low selects A, high selects B; strap high: each channel's CFG_MUX_B bit selects
			for (int i = 0; i < vbc_pkg::NUM_CH; i++)
				mux_ff[i] <= src_sync_ff[1] ? cfg_ff[i][vbc_pkg::CFG_MUX_B] : pin_sync_ff[1];
		end
	end

	assign sda_o       = 1'b0;
	assign sda_oe_o    = sda_oe_ff;
	assign ch_cfg_o    = ch_cfg_ff;
	assign sync_cfg_o  = sync_cfg_ff;
	assign mux_sel_b_o = mux_ff;

endmodule : vbc_control_port

`default_nettype wire

// [vbc_pkg.sv]
package vbc_pkg;

	// fixed upper bits of the 7-bit slave address
	localparam logic [4:0] ADDR_FIXED   = 5'h0B;
	localparam int         NUM_CH       = 3;
	localparam logic [1:0] PTR_SYNC     = 2'h3;

	// channel configuration byte layout
	localparam int         CFG_MUX_B    = 0;
	localparam int         CFG_BIAS_LO  = 1;
	localparam int         CFG_MON_EN   = 3;
	localparam int         CFG_BUF_EN   = 4;
	localparam int         CFG_FILT_LO  = 5;

	// sync register layout
	localparam int         SYNC_H_EN    = 0;
	localparam int         SYNC_V_EN    = 1;

	// power-up values: all off, or monitor on in ac-bias with syncs on
	localparam logic [7:0] CH_RST_OFF   = 8'h00;
	localparam logic [7:0] CH_RST_MON   = 8'h08;
	localparam logic [7:0] SYNC_RST_OFF = 8'h00;
	localparam logic [7:0] SYNC_RST_ON  = 8'h03;

	// cycles of clk_i before the strap synchronisers are trusted
	localparam logic [1:0] STRAP_WAIT   = 2'h3;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_ADDR  = 6'b000010,
		ST_ACK   = 6'b000100,
		ST_RX    = 6'b001000,
		ST_TX    = 6'b010000,
		ST_TXACK = 6'b100000
	} vbc_state_type;

endpackage : vbc_pkg

// [vbc_control_port_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module vbc_control_port_props (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        scl_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o,
	input wire logic        power_up_state_strap_i,
	input wire logic        input_select_source_strap_i,
	input wire logic        input_select_pin_i,
	input wire logic [23:0] ch_cfg_o,
	input wire logic [7:0]  sync_cfg_o,
	input wire logic [2:0]  mux_sel_b_o
);
	// ====================
	// bus and config checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_drive_low_only: assert property ($changed(sda_oe_o) |-> !sda_o && !scl_i)
		else $error("sda drive changed while scl high");
	a_ack_in_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("sda pulled while scl high");
	a_ack_held: assert property ($rose(scl_i) && sda_oe_o |-> sda_oe_o [*8])
		else $error("ack dropped in high phase");
	a_ack_release: assert property ($fell(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("sda released while scl high");
	a_pu_off: assert property ($rose(reset_n_i) && !power_up_state_strap_i |-> ##8 ch_cfg_o == 24'h0 && sync_cfg_o == 8'h0)
		else $error("power-up not all off");
	a_pu_monitor: assert property ($rose(reset_n_i) && power_up_state_strap_i |-> ##8 ch_cfg_o == 24'h080808 && sync_cfg_o == 8'h03)
		else $error("power-up monitor state wrong");
	a_mux_by_pin: assert property ((!input_select_source_strap_i && $stable(input_select_pin_i)) [*6] |-> mux_sel_b_o == {3{input_select_pin_i}})
		else $error("mux does not follow pin");
	a_mux_serial: assert property ((input_select_source_strap_i && $stable(ch_cfg_o)) [*6] |-> mux_sel_b_o == {ch_cfg_o[16], ch_cfg_o[8], ch_cfg_o[0]})
		else $error("mux does not follow serial setting");
	a_one_channel: assert property ($changed(ch_cfg_o) && $past(reset_n_i, 10) |-> $onehot0({ch_cfg_o[23:16] != $past(ch_cfg_o[23:16]),
		ch_cfg_o[15:8] != $past(ch_cfg_o[15:8]), ch_cfg_o[7:0] != $past(ch_cfg_o[7:0])})) else $error("several channels changed");
	c_ack: cover property ($rose(sda_oe_o));
	c_mux_b: cover property (mux_sel_b_o == 3'h7);
	c_pu_mon: cover property (sync_cfg_o == 8'h03);
endmodule : vbc_control_port_props
bind vbc_control_port vbc_control_port_props u_props (.clk_i, .reset_n_i, .scl_i, .sda_o, .sda_oe_o, .power_up_state_strap_i,
	.input_select_source_strap_i, .input_select_pin_i, .ch_cfg_o, .sync_cfg_o, .mux_sel_b_o);
`default_nettype wire

// [vbc_i2c_master.sv]
`timescale 1ns/1ps
`default_nettype none
module vbc_i2c_master (
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	// ====================
	// open-drain bus master model
	initial begin
		scl_o = 1'h1;
		sda_low_o = 1'h0;
	end
	// 400 kbps: 1.3 us low, 1.2 us high
	task automatic clk_bit(input logic b, output logic r);
		#300 sda_low_o = !b;
		#1000 scl_o = 1'h1;
		#600 r = sda_i;
		#600 scl_o = 1'h0;
	endtask : clk_bit
	task automatic start();
		#300 sda_low_o = 1'h0;
		#1000 scl_o = 1'h1;
		#1300 sda_low_o = 1'h1;
		#1300 scl_o = 1'h0;
	endtask : start
	task automatic stop();
		#300 sda_low_o = 1'h1;
		#1000 scl_o = 1'h1;
		#1300 sda_low_o = 1'h0;
		#1300;
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], q[i]);
		clk_bit(a, r);
	endtask : xfer
endmodule : vbc_i2c_master
`default_nettype wire

// [tb_video_buffer_control_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_video_buffer_control_port;
	// ====================
	// stimulus and checks
	logic clk_i = 1'h0, reset_n_i = 1'h0, pu = 1'h0, src = 1'h0, pin = 1'h0, adr1 = 1'h0, adr0 = 1'h0;
	logic scl, m_low, sda_o, sda_oe;
	logic [23:0] ch;
	logic [7:0] sync;
	logic [2:0] mux;
	int num_errors = 0, checks = 0, cyc = 0;
	// pull-up: the line is low while either side pulls
	wire logic sda = !m_low && (sda_oe ? sda_o : 1'h1);
	always #4 clk_i = !clk_i;
	vbc_control_port u_dut (.clk_i, .reset_n_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o(sda_oe),
		.address_strap_bit1_i(adr1), .address_strap_bit0_i(adr0), .power_up_state_strap_i(pu),
		.input_select_source_strap_i(src), .input_select_pin_i(pin), .ch_cfg_o(ch), .sync_cfg_o(sync), .mux_sel_b_o(mux));
	vbc_i2c_master u_master (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [23:0] got, exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic put(input logic [7:0] b);
		logic [7:0] q;
		logic r;
		u_master.xfer(b, 1'h1, q, r);
		chk(r, 1'h0);
	endtask : put
	task automatic t_power(input logic p, b1, b0);
		@(negedge clk_i);
		reset_n_i = 1'h0;
		pu = p;
		adr1 = b1;
		adr0 = b0;
		repeat (20) @(negedge clk_i);
		reset_n_i = 1'h1;
		repeat (12) @(negedge clk_i);
		chk(ch, p ? 24'h080808 : 24'h0);
		chk(sync, p ? 8'h03 : 8'h0);
		// power strap moved after power-up must leave the settings alone
		pu = !p;
		repeat (10) @(negedge clk_i);
		chk(ch, p ? 24'h080808 : 24'h0);
		chk(sync, p ? 8'h03 : 8'h0);
		pu = p;
	endtask : t_power
	task automatic t_addr();
		logic [7:0] q;
		logic r;
		logic [1:0] lo;
		lo = {adr1, adr0};
		// address straps moved after power-up must not move the address
		@(negedge clk_i);
		{adr1, adr0} = ~lo;
		u_master.start();
		u_master.xfer({5'h0B, ~lo[1], lo[0], 1'h0}, 1'h1, q, r);
		u_master.stop();
		chk(r, 1'h1);
		u_master.start();
		put({5'h0B, lo, 1'h0});
		u_master.stop();
		@(negedge clk_i);
		{adr1, adr0} = lo;
		u_master.start();
		put({5'h0B, lo, 1'h0});
		u_master.stop();
	endtask : t_addr
	task automatic t_write();
		u_master.start();
		put({5'h0B, adr1, adr0, 1'h0});
		put(8'h01);
		put(8'h15);
		put(8'h2E);
		put(8'h02);
		put(8'h11);
		u_master.stop();
		chk(ch, 24'h2E1511);
		chk(sync, 8'h02);
		u_master.start();
		put({5'h0B, adr1, adr0, 1'h0});
		put(8'h01);
		put(8'h1E);
		u_master.stop();
		chk(ch, 24'h2E1E11);
	endtask : t_write
	task automatic t_read();
		logic [31:0] e = 32'h111E2E02;
		logic [7:0] q;
		logic r;
		u_master.start();
		put({5'h0B, adr1, adr0, 1'h0});
		put(8'h00);
		u_master.start();
		put({5'h0B, adr1, adr0, 1'h1});
		for (int i = 0; i < 4; i++) begin
			u_master.xfer(8'hFF, i == 3, q, r);
			chk(q, e[31 - 8 * i -: 8]);
		end
		u_master.stop();
	endtask : t_read
	task automatic mux_is(input logic [2:0] e);
		for (int i = 0; i < 20 && mux !== e; i++)
			@(negedge clk_i);
		chk(mux, e);
	endtask : mux_is
	task automatic t_mux();
		@(negedge clk_i);
		pin = 1'h1;
		mux_is(3'h7);
		pin = 1'h0;
		mux_is(3'h0);
		src = 1'h1;
		mux_is(3'h1);
		pin = 1'h1;
		repeat (10) @(negedge clk_i);
		chk(mux, 3'h1);
	endtask : t_mux
	// a hang still reaches the report
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		t_power(1'h0, 1'h1, 1'h0);
		t_addr();
		t_write();
		t_read();
		t_mux();
		t_power(1'h1, 1'h0, 1'h1);
		t_addr();
		end_sim();
	end
endmodule : tb_video_buffer_control_port
`default_nettype wire
